// ---- design/csb_pkg.sv ----
// package: register map, field layout and bus-cycle states of the chip-select block
package csb_pkg;
    localparam int          ADDR_W        = 20;
    localparam int          PADDR_W       = 12;
    // printed offsets are register indices; byte address is four times the index
    localparam logic [7:0]  IDX_UPPER     = 8'ha0;
    localparam logic [7:0]  IDX_LOWER     = 8'ha2;
    localparam logic [7:0]  IDX_MID_BASE  = 8'ha6;
    localparam logic [7:0]  IDX_MID_SIZE  = 8'ha8;
    localparam logic [7:0]  IDX_STATUS    = 8'haa;
    localparam logic [15:0] UPPER_RESET   = 16'hf03b;
    localparam logic [15:0] UPPER_WMASK   = 16'h7087;
    localparam logic [15:0] UPPER_FIXED   = 16'h8038;
    localparam logic [15:0] LOWER_WMASK   = 16'h70c7;
    localparam logic [15:0] LOWER_FIXED   = 16'h0f38;
    localparam logic [15:0] MBASE_WMASK   = 16'hfe07;
    localparam logic [15:0] MBASE_FIXED   = 16'h01f8;
    localparam logic [15:0] MSIZE_WMASK   = 16'h7f07;
    localparam logic [15:0] MSIZE_FIXED   = 16'h0000;
    localparam int          WSIZE_LSB     = 12;
    localparam int          DA_BIT        = 7;
    localparam int          RRAM_BIT      = 6;
    localparam int          RIGN_BIT      = 2;
    localparam int          MBASE_LSB     = 9;
    localparam int          MSIZE_LSB     = 8;
    localparam int          BASE_SHIFT    = 13;
    localparam int          QUARTER_SHIFT = 11;
    localparam logic [1:0]  STRAP_SETTLE  = 2'h3;
    localparam logic [1:0]  WAIT_MAX      = 2'h3;
    typedef enum logic [6:0] {
        ST_IDLE = 7'b0000001,
        ST_T1   = 7'b0000010,
        ST_T2   = 7'b0000100,
        ST_T3   = 7'b0001000,
        ST_TW   = 7'b0010000,
        ST_T4   = 7'b0100000,
        ST_HOLD = 7'b1000000
    } csb_state_t;
endpackage : csb_pkg

// ---- design/csb_chip_select.sv ----
// chip-select generator with wait states, address-phase control and bus hold
`timescale 1ns/10ps
module csb_chip_select
    import csb_pkg::*;
#(
    parameter int MID_N = 4
) (
    input  wire logic                i_clk_sys,
    input  wire logic                i_rst_n,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [PADDR_W-1:0]  paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                i_cyc_req,
    input  wire logic                i_cyc_mem,
    input  wire logic [ADDR_W-1:0]   i_cyc_addr,
    input  wire logic                i_hold_req,
    input  wire logic                i_async_ready_in,
    input  wire logic                i_sync_ready_in,
    input  wire logic                i_addr_enable_strap,
    output logic                     o_cyc_start,
    output logic                     o_cyc_done,
    output logic                     o_upper_mem_select_n,
    output logic                     o_lower_mem_select_n,
    output logic      [MID_N-1:0]    o_midrange_selects_n,
    output logic                     o_addr_phase_drive,
    output logic                     o_bus_float,
    output logic                     o_hold_ack,
    output logic                     o_refreshed_ram_mode
);
    function automatic logic upper_hit(input logic [ADDR_W-1:0] a, input logic [2:0] c);
        upper_hit = a[19] && ((a[18:16] & c) == c);
    endfunction : upper_hit

    function automatic logic lower_hit(input logic [ADDR_W-1:0] a, input logic [2:0] c);
        lower_hit = !a[19] && ((a[18:16] & ~c) == 3'h0);
    endfunction : lower_hit

    function automatic logic [2:0] size_log(input logic [6:0] m);
        size_log = 3'h0;
        for (int k = 0; k < 7; k++) begin
            if (m[k]) begin
                size_log = 3'(k);
            end
        end
    endfunction : size_log

    // pin synchronisers: hold, async ready, sync ready, strap
    logic [3:0] pin_raw;
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    logic [3:0] sync3_r;
    logic [3:0] pin_f_r;
    logic [3:0] pin_f_nxt;
    assign pin_raw   = {i_addr_enable_strap, i_sync_ready_in, i_async_ready_in, i_hold_req};
    // a change counts once the second and third stages agree
    assign pin_f_nxt = (sync2_r & sync3_r) | (pin_f_r & (sync2_r ^ sync3_r));

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1_r <= 4'h6;
            sync2_r <= 4'h6;
            sync3_r <= 4'h6;
            pin_f_r <= 4'h6;
        end else begin
            sync1_r <= pin_raw;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            pin_f_r <= pin_f_nxt;
        end
    end

    logic hold_f;
    logic ready_f;
    assign hold_f  = pin_f_r[0];
    // both ready pins idle high; either one low stretches the cycle
    assign ready_f = pin_f_r[1] & pin_f_r[2];

    // strap caught once the synchroniser has settled after reset release
    logic [1:0] strap_cnt_r;
    logic       strap_done_r;
    logic       da_valid_r;
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            strap_cnt_r  <= 2'h0;
            strap_done_r <= 1'b0;
            da_valid_r   <= 1'b0;
        end else if (!strap_done_r) begin
            strap_cnt_r <= strap_cnt_r + 2'h1;
            if (strap_cnt_r == STRAP_SETTLE) begin
                strap_done_r <= 1'b1;
                da_valid_r   <= pin_f_nxt[3];
            end
        end
    end

    // register bus slave, zero wait, read data prepared in the setup phase
    logic [15:0] upper_r;
    logic [15:0] lower_r;
    logic [15:0] mbase_r;
    logic [15:0] msize_r;
    logic        lower_en_r;
    logic        mbase_seen_r;
    logic        msize_seen_r;
    logic        mid_en;
    logic [7:0]  reg_idx;
    logic        idx_ok;
    logic        setup_ph;
    logic        access_ph;
    logic        wr_upper;
    logic        wr_lower;
    logic        wr_mbase;
    logic        wr_msize;
    logic        acc_lower;
    logic        acc_mbase;
    logic        acc_msize;
    logic        rd_sel_known;
    logic [15:0] rd_word;
    logic [15:0] wdata16;
    logic [15:0] status_word;

    assign reg_idx      = paddr[9:2];
    assign idx_ok       = (paddr[1:0] == 2'h0) && (paddr[PADDR_W-1:10] == 2'h0);
    assign setup_ph     = psel && !penable;
    assign access_ph    = psel && penable && pready;
    assign wdata16      = pwdata[15:0];
    assign acc_lower    = access_ph && idx_ok && (reg_idx == IDX_LOWER);
    assign acc_mbase    = access_ph && idx_ok && (reg_idx == IDX_MID_BASE);
    assign acc_msize    = access_ph && idx_ok && (reg_idx == IDX_MID_SIZE);
    assign wr_upper     = access_ph && pwrite && idx_ok && (reg_idx == IDX_UPPER);
    assign wr_lower     = acc_lower && pwrite;
    assign wr_mbase     = acc_mbase && pwrite;
    assign wr_msize     = acc_msize && pwrite;
    assign mid_en       = mbase_seen_r && msize_seen_r;
    assign rd_sel_known = idx_ok && (reg_idx == IDX_UPPER || reg_idx == IDX_LOWER ||
                          reg_idx == IDX_MID_BASE || reg_idx == IDX_MID_SIZE ||
                          reg_idx == IDX_STATUS);

    csb_state_t state_r;
    csb_state_t state_nxt;
    assign status_word = {11'h0, (state_r != ST_IDLE && state_r != ST_HOLD), mid_en,
                          lower_en_r, da_valid_r, o_hold_ack};

    always_comb begin
        rd_word = 16'h0;
        if (idx_ok) begin
            unique case (reg_idx)
                IDX_UPPER:    rd_word = (upper_r & UPPER_WMASK) | UPPER_FIXED;
                IDX_LOWER:    rd_word = (lower_r & LOWER_WMASK) | LOWER_FIXED;
                IDX_MID_BASE: rd_word = (mbase_r & MBASE_WMASK) | MBASE_FIXED;
                IDX_MID_SIZE: rd_word = (msize_r & MSIZE_WMASK) | MSIZE_FIXED;
                IDX_STATUS:   rd_word = status_word;
                default:      rd_word = 16'h0;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prdata  <= 32'h0;
            pslverr <= 1'b0;
            pready  <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (setup_ph) begin
                prdata  <= {16'h0, rd_word};
                pslverr <= !rd_sel_known || (pwrite && reg_idx == IDX_STATUS);
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            upper_r      <= UPPER_RESET;
            lower_r      <= 16'h0;
            mbase_r      <= 16'h0;
            msize_r      <= 16'h0;
            lower_en_r   <= 1'b0;
            mbase_seen_r <= 1'b0;
            msize_seen_r <= 1'b0;
        end else begin
            if (wr_upper) upper_r <= wdata16 & UPPER_WMASK;
            if (wr_lower) lower_r <= wdata16 & LOWER_WMASK;
            if (wr_mbase) mbase_r <= wdata16 & MBASE_WMASK;
            if (wr_msize) msize_r <= wdata16 & MSIZE_WMASK;
            if (acc_lower) lower_en_r <= 1'b1;
            if (acc_mbase) mbase_seen_r <= 1'b1;
            if (acc_msize) msize_seen_r <= 1'b1;
        end
    end

    // window decode on the address of the cycle being started or running
    logic [ADDR_W-1:0] addr_r;
    logic              mem_r;
    logic              take;
    logic [ADDR_W-1:0] dec_addr;
    logic              dec_mem;
    logic              hit_up;
    logic              hit_lo;
    logic              hit_mid;
    logic [ADDR_W-1:0] mid_base;
    logic [ADDR_W-1:0] mid_off;
    logic [2:0]        mid_log;
    logic [ADDR_W-1:0] mid_blk;
    logic [1:0]        mid_idx;

    assign take     = (state_nxt == ST_T1);
    assign dec_addr = take ? i_cyc_addr : addr_r;
    assign dec_mem  = take ? i_cyc_mem : mem_r;
    assign hit_up   = dec_mem && upper_hit(dec_addr, upper_r[WSIZE_LSB+2:WSIZE_LSB]);
    assign hit_lo   = dec_mem && lower_en_r && !hit_up &&
                      lower_hit(dec_addr, lower_r[WSIZE_LSB+2:WSIZE_LSB]);
    // midrange base low bits forced to zero; base kept aligned by software
    assign mid_base = {mbase_r[15:MBASE_LSB], 13'h0};
    assign mid_off  = dec_addr - mid_base;
    assign mid_log  = size_log(msize_r[MSIZE_LSB+6:MSIZE_LSB]);
    assign mid_blk  = mid_off >> (BASE_SHIFT + int'(mid_log));
    assign mid_idx  = 2'(mid_off >> (QUARTER_SHIFT + int'(mid_log)));
    // upper and lower win, so an overlap never drives two selects
    assign hit_mid  = dec_mem && mid_en && !hit_up && !hit_lo && (dec_addr >= mid_base) &&
                      (msize_r[MSIZE_LSB+6:MSIZE_LSB] != 7'h0) &&
                      (mid_blk == 20'h0);

    logic [1:0] cfg_wait;
    logic       cfg_ign;
    logic       cfg_da;
    assign cfg_wait = hit_up ? upper_r[1:0] : hit_lo ? lower_r[1:0] :
                      hit_mid ? mbase_r[1:0] : 2'h0;
    assign cfg_ign  = hit_up ? upper_r[RIGN_BIT] : hit_lo ? lower_r[RIGN_BIT] :
                      hit_mid ? mbase_r[RIGN_BIT] : 1'b0;
    assign cfg_da   = hit_up ? upper_r[DA_BIT] : hit_lo ? lower_r[DA_BIT] : 1'b0;

    // bus-cycle sequencer
    logic [1:0] cur_wait_r;
    logic       cur_ign_r;
    logic [1:0] wcnt_r;
    logic       rdy_ok;
    logic       waits_met;
    logic       in_cyc_nxt;
    assign rdy_ok    = cur_ign_r || ready_f;
    assign waits_met = (wcnt_r >= cur_wait_r);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (hold_f) state_nxt = ST_HOLD;
                else if (i_cyc_req) state_nxt = ST_T1;
            end
            ST_T1:   state_nxt = ST_T2;
            ST_T2:   state_nxt = ST_T3;
            ST_T3: begin
                if (cur_wait_r == 2'h0 && rdy_ok) state_nxt = ST_T4;
                else state_nxt = ST_TW;
            end
            ST_TW: begin
                if (waits_met && rdy_ok) state_nxt = ST_T4;
            end
            ST_T4: begin
                if (hold_f) state_nxt = ST_HOLD;
                else if (i_cyc_req) state_nxt = ST_T1;
                else state_nxt = ST_IDLE;
            end
            ST_HOLD: begin
                if (!hold_f) state_nxt = ST_IDLE;
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    assign in_cyc_nxt = (state_nxt != ST_IDLE) && (state_nxt != ST_HOLD);

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r    <= ST_IDLE;
            addr_r     <= 20'h0;
            mem_r      <= 1'b0;
            cur_wait_r <= 2'h0;
            cur_ign_r  <= 1'b0;
            wcnt_r     <= 2'h0;
        end else begin
            state_r <= state_nxt;
            if (take) begin
                addr_r     <= i_cyc_addr;
                mem_r      <= i_cyc_mem;
                cur_wait_r <= cfg_wait;
                cur_ign_r  <= cfg_ign;
            end
            if (state_nxt == ST_TW) begin
                wcnt_r <= (state_r == ST_TW && wcnt_r != WAIT_MAX) ? wcnt_r + 2'h1 : wcnt_r;
            end
            if (state_r == ST_T3) wcnt_r <= 2'h1;
        end
    end

    // outputs other than o_refreshed_ram_mode registered from the next state so they line up with the T-states
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_upper_mem_select_n <= 1'b1;
            o_lower_mem_select_n <= 1'b1;
            o_midrange_selects_n <= '1;
            o_addr_phase_drive   <= 1'b0;
            o_bus_float          <= 1'b0;
            o_hold_ack           <= 1'b0;
            o_cyc_start          <= 1'b0;
            o_cyc_done           <= 1'b0;
            o_refreshed_ram_mode <= 1'b0;
        end else begin
            o_upper_mem_select_n <= !(in_cyc_nxt && hit_up);
            o_lower_mem_select_n <= !(in_cyc_nxt && hit_lo);
            for (int i = 0; i < MID_N; i++) begin
                o_midrange_selects_n[i] <= !(in_cyc_nxt && hit_mid && mid_idx == 2'(i));
            end
            // address phase skipped only when the strap made the bit valid
            o_addr_phase_drive   <= take && !(da_valid_r && cfg_da);
            o_bus_float          <= (state_nxt == ST_HOLD);
            o_hold_ack           <= (state_nxt == ST_HOLD);
            o_cyc_start          <= take;
            o_cyc_done           <= (state_nxt == ST_T4);
            // refresh must be set up first; this only flags the lower region
            o_refreshed_ram_mode <= lower_r[RRAM_BIT];
        end
    end

    logic was_idle_or_t4;
    assign was_idle_or_t4 = (state_r == ST_IDLE) || (state_r == ST_T4);

    a_hold_ack_edge: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        $rose(o_hold_ack) |-> $past(was_idle_or_t4))
        else $error("hold ack rose outside T4 or idle");
    a_hold_float_sel: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        o_hold_ack |-> (o_bus_float && o_upper_mem_select_n && o_lower_mem_select_n &&
                        (&o_midrange_selects_n) && !o_addr_phase_drive))
        else $error("bus not released during hold");
    a_hold_release: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (state_r == ST_HOLD && !hold_f) |=> !o_hold_ack)
        else $error("hold ack kept after request low");
    a_upper_four_clk: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        ($fell(o_upper_mem_select_n) && cur_ign_r && cur_wait_r == 2'h0)
        |-> !o_upper_mem_select_n [*4] ##1 (o_upper_mem_select_n || state_r == ST_T1))
        else $error("upper select length wrong");
    a_wait_two: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (state_r == ST_T3 && cur_ign_r && cur_wait_r == 2'h2)
        |=> (state_r == ST_TW) [*2] ##1 (state_r == ST_T4))
        else $error("two waits not inserted");
    a_ready_stretch: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (state_r == ST_TW && !cur_ign_r && !ready_f) |=> (state_r == ST_TW))
        else $error("cycle ended without ready");
    a_lower_gate: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !$past(lower_en_r) |-> o_lower_mem_select_n)
        else $error("lower select before enable");
    a_mid_gate: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !$past(mid_en) |-> (&o_midrange_selects_n))
        else $error("midrange select before enable");
    a_strap_addr: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (o_cyc_start && !da_valid_r) |-> o_addr_phase_drive)
        else $error("address phase dropped with strap low");
    a_upper_window: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (state_r == ST_T1 && mem_r && upper_hit(addr_r, upper_r[14:12])) |->
        !o_upper_mem_select_n)
        else $error("upper select missing in window");

    c_hold: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) $rose(o_hold_ack));
    c_waits: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        state_r == ST_TW ##1 state_r == ST_TW ##1 state_r == ST_TW);
    c_mid: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !o_midrange_selects_n[MID_N-1]);
    c_lower: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !o_lower_mem_select_n);
endmodule : csb_chip_select

// ---- testbench/csb_far_model.sv ----
// far side: slow memory ready and a second bus master
`timescale 1ns/10ps
module csb_far_model (
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst_n,
    input  wire logic       i_cyc_start,
    input  wire logic       i_hold_on,
    input  wire logic [3:0] i_stall,
    output logic            o_async_ready_in,
    output logic            o_sync_ready_in,
    output logic            o_hold_req
);
    logic [3:0] stall_r;
    // memory holds ready low for a set count per cycle
    assign o_async_ready_in = (stall_r == 4'h0);
    // sync ready pin only has its pull-up here
    assign o_sync_ready_in  = 1'b1;
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stall_r    <= 4'h0;
            o_hold_req <= 1'b0;
        end else begin
            o_hold_req <= i_hold_on;
            if (i_cyc_start)
                stall_r <= i_stall;
            else if (stall_r != 4'h0)
                stall_r <= stall_r - 4'h1;
        end
    end
endmodule : csb_far_model

// ---- testbench/testbench.sv ----
// self-checking bench for the chip-select and bus-hold block
`timescale 1ns/10ps
module testbench;
    import csb_pkg::*;
    logic        i_clk_sys = 1'b0;
    logic        i_rst_n   = 1'b0;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [11:0] paddr     = 12'h000;
    logic [31:0] pwdata    = 32'h0;
    logic        cyc_req   = 1'b0;
    logic [19:0] cyc_addr  = 20'h0;
    logic        hold_on   = 1'b0;
    logic        strap     = 1'b1;
    logic        cyc_mem   = 1'b1;
    logic [3:0]  stall     = 4'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic [3:0]  mcs_n;
    logic [3:0]  cm;
    logic        pready, pslverr, hold_req, async_ready_in, sync_ready_in, start, done;
    logic        ucs_n, lcs_n, ad_drv, flt, hack, rram, err;
    int          cu, cl, ad, bad_count, checks;

    always #5 i_clk_sys = ~i_clk_sys;

    csb_chip_select #(.MID_N(4)) dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .i_cyc_req(cyc_req),
        .i_cyc_mem(cyc_mem), .i_cyc_addr(cyc_addr), .i_hold_req(hold_req),
        .i_async_ready_in(async_ready_in), .i_sync_ready_in(sync_ready_in), .i_addr_enable_strap(strap),
        .o_cyc_start(start), .o_cyc_done(done), .o_upper_mem_select_n(ucs_n),
        .o_lower_mem_select_n(lcs_n), .o_midrange_selects_n(mcs_n),
        .o_addr_phase_drive(ad_drv), .o_bus_float(flt), .o_hold_ack(hack),
        .o_refreshed_ram_mode(rram));

    csb_far_model far (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_cyc_start(start),
        .i_hold_on(hold_on), .i_stall(stall), .o_async_ready_in(async_ready_in),
        .o_sync_ready_in(sync_ready_in), .o_hold_req(hold_req));

    task automatic results();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // a used-up bound ends the run
    task automatic lim(input int n);
        if (n >= 40) begin
            bad_count++;
            results();
        end
    endtask : lim

    task automatic apb(input logic wr, input logic [7:0] idx, input logic [15:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {16'h0, d};
        @(posedge i_clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge i_clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 40);
        lim(n);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // one idle edge so a following call never re-drives psel in this step
        @(posedge i_clk_sys);
    endtask : apb

    // one bus cycle; counts select-low cycles from T1 to T4
    task automatic cyc(input logic [19:0] a);
        int n;
        n = 0;
        cu = 0;
        cl = 0;
        ad = 0;
        cm = 4'h0;
        cyc_addr <= a;
        cyc_req  <= 1'b1;
        do begin
            @(posedge i_clk_sys);
            n++;
            if (start === 1'b1)
                cyc_req <= 1'b0;
            cu += int'(ucs_n === 1'b0);
            cl += int'(lcs_n === 1'b0);
            ad += int'(ad_drv === 1'b1);
            cm |= ~mcs_n;
        end while (done !== 1'b1 && n < 40);
        lim(n);
    endtask : cyc

    task automatic wait_ack(input logic v);
        int n;
        n = 0;
        while (hack !== v && n < 40) begin
            @(posedge i_clk_sys);
            n++;
        end
        lim(n);
    endtask : wait_ack

    task automatic t_reset();
        cyc_mem <= 1'b0;
        cyc(20'hffff0);
        chk("io_no_select", 0, cu);
        cyc_mem <= 1'b1;
        cyc(20'h00100);
        chk("lower_idle", 0, cl);
        cyc(20'hffff0);
        chk("upper_reset_len", 7, cu);
        chk("addr_phase", 1, ad);
        apb(1'b0, IDX_UPPER, 16'h0);
        chk("upper_reset", 32'hf03b, rd);
        apb(1'b0, 8'ha4, 16'h0);
        chk("unmapped_err", 1, err);
    endtask : t_reset

    task automatic t_upper();
        logic [2:0]  sz [4] = '{3'h7, 3'h6, 3'h4, 3'h0};
        logic [19:0] st [4] = '{20'hf0000, 20'he0000, 20'hc0000, 20'h80000};
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, IDX_UPPER, {1'b0, sz[i], 12'h004});
            cyc(st[i]);
            chk("upper_in", 4, cu);
            cyc(st[i] - 20'h1);
            chk("upper_out", 0, cu);
        end
    endtask : t_upper

    // memory stalls throughout; ignored unless ready is required
    task automatic t_waits();
        stall <= 4'h8;
        for (int w = 0; w < 4; w++) begin
            apb(1'b1, IDX_UPPER, 16'h7004 | 16'(w));
            cyc(20'hffff0);
            chk("wait_len", 4 + w, cu);
        end
        // three waits give the ready synchroniser time to see the stall
        apb(1'b1, IDX_UPPER, 16'h7003);
        cyc(20'hffff0);
        chk("ready_stretch", 1, cu > 7);
        stall <= 4'h0;
        apb(1'b1, IDX_UPPER, 16'h7084);
        cyc(20'hffff0);
        chk("addr_omitted", 0, ad);
    endtask : t_waits

    task automatic t_lower();
        logic [2:0]  sz [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
        logic [19:0] en [4] = '{20'h0ffff, 20'h1ffff, 20'h3ffff, 20'h7ffff};
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, IDX_LOWER, {1'b0, sz[i], 12'h004} | (i == 1 ? 16'h0040 : 16'h0));
            cyc(en[i]);
            chk("refreshed_ram", i == 1, rram);
            chk("lower_in", 4, cl);
            cyc(en[i] + 20'h1);
            chk("lower_out", 0, cl);
        end
    endtask : t_lower

    task automatic t_mid();
        // shrink the lower window so the midrange block does not overlap it
        apb(1'b1, IDX_LOWER, 16'h0004);
        apb(1'b1, IDX_MID_BASE, 16'h2004);
        cyc(20'h20000);
        chk("mid_half", 0, cm);
        apb(1'b1, IDX_MID_SIZE, 16'h0400);
        cyc(20'h20000);
        chk("mid_q0", 1, cm);
        cyc(20'h26000);
        chk("mid_q3", 8, cm);
    endtask : t_mid

    task automatic t_hold();
        hold_on <= 1'b1;
        wait_ack(1'b1);
        chk("hold_ack", 1, hack);
        chk("hold_float", 1, flt);
        chk("hold_selects", 6'h3f, {ucs_n, lcs_n, mcs_n});
        hold_on <= 1'b0;
        wait_ack(1'b0);
        chk("hold_drop", 0, hack);
    endtask : t_hold

    // strap low at reset release: address disable bit has no effect
    task automatic t_strap();
        strap   <= 1'b0;
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        repeat (10) @(posedge i_clk_sys);
        apb(1'b1, IDX_UPPER, 16'h7084);
        cyc(20'hffff0);
        chk("addr_strap_low", 1, ad);
        chk("upper_strap_len", 4, cu);
    endtask : t_strap

    initial begin
        repeat (12) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        repeat (10) @(posedge i_clk_sys);
        t_reset();
        t_upper();
        t_waits();
        t_lower();
        t_mid();
        t_hold();
        t_strap();
        results();
    end
endmodule : testbench
